// file: include/scc_defines.svh
// Purpose: Offsets, field positions, reset values and counts of the block.
// Assumes: Register index times four gives the APB byte address.
// Notes: Constants only; no logic lives here.
`ifndef SCC_DEFINES_SVH
`define SCC_DEFINES_SVH

// Register indexes, compared against paddr[11:2].
`define SCC_IDX_CTRL0 10'h0E0
`define SCC_IDX_CLKSEL 10'h0E1
`define SCC_IDX_MODE 10'h0E2
`define SCC_IDX_NOISE 10'h0E3
`define SCC_IDX_KEY 10'h0E4
`define SCC_IDX_DBL_A 10'h0E8
`define SCC_IDX_DBL_B 10'h0E9

// Field positions.
`define SCC_CTRL0_WUF 2
`define SCC_CLKSEL_SRC 3
`define SCC_MODE_CLKOUT 6
`define SCC_MODE_WUP_LO 4
`define SCC_MODE_STB_LO 2
`define SCC_MODE_HOLD 0
`define SCC_NOISE_PROT 7
`define SCC_NOISE_SPARE_LO 4
`define SCC_NOISE_ALE 3
`define SCC_NOISE_EXT 2
`define SCC_NOISE_DRVH 1
`define SCC_NOISE_DRVL 0
`define SCC_DBL_A_TM 4

// Reset values.
`define SCC_RST_GEAR 3'h4
`define SCC_RST_WUP 2'h2
`define SCC_RST_STB 2'h3
`define SCC_RST_SPARE 3'h2
`define SCC_RST_DBL_B 8'h13

// Protection key and warm-up lengths in input clock periods.
`define SCC_KEY_OPEN 8'h1F
`define SCC_WUP_SHORT_CYC 17'h00100
`define SCC_WUP_MID_CYC 17'h04000
`define SCC_WUP_LONG_CYC 17'h10000

`endif

// file: include/scc_pkg.sv
// Purpose: Types shared by the clock configuration block.
// Assumes: Used together with scc_defines.svh.
// Notes: Holds enums and structs only.
package scc_pkg;

  typedef enum logic [1:0]
  {
    SCC_STB_RSVD = 2'b00,
    SCC_STB_STOP = 2'b01,
    SCC_STB_IDLE_ONE = 2'b10,
    SCC_STB_IDLE_TWO = 2'b11
  } scc_standby_e;

  typedef struct packed
  {
    logic system_clock_source_sel;
    logic clock_out_sel;
    logic [2:0] gear_sel;
    logic [1:0] prescaler_source_sel;
    logic [1:0] warmup_time_sel;
    scc_standby_e standby_mode;
    logic standby_pin_hold;
    logic latch_strobe_out_enable;
    logic external_fast_clock_in;
    logic fast_osc_drive;
    logic slow_osc_drive;
    logic protect;
  } scc_ctrl_s;

  typedef struct packed
  {
    scc_ctrl_s ctrl;
    logic [2:0] spare;
    logic dbl_a_tm;
    logic [7:0] dbl_b;
    logic [7:0] rdata;
  } scc_state_s;

  typedef struct packed
  {
    logic busy;
    logic [16:0] cnt;
  } scc_wup_state_s;

endpackage

// file: rtl/scc_warmup.sv
// Purpose: Warm-up timer counting a programmed number of clock periods.
// Assumes: start is a one-cycle pulse from logic on the same clock.
// Notes: A start while busy restarts the count from the new length.
`timescale 1ns/1ps
`include "scc_defines.svh"
`default_nettype none

module scc_warmup
  import scc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  input wire logic [16:0] length,
  output logic busy
);

  scc_wup_state_s st_r;
  scc_wup_state_s st_nxt;

  // A start always wins, so a restart is never lost to a finishing count.
  always_comb
  begin
    st_nxt = st_r;
    if (start)
    begin
      st_nxt.busy = 1'b1;
      st_nxt.cnt = length - 17'h00001;
    end
    else if (st_r.busy)
    begin
      if (st_r.cnt == 17'h00000)
        st_nxt.busy = 1'b0;
      else
        st_nxt.cnt = st_r.cnt - 17'h00001;
    end
  end

  // State register.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign busy = st_r.busy;

endmodule

`default_nettype wire

// file: rtl/scc_top.sv
// Purpose: Software view of system clock, standby and noise settings.
// Assumes: APB slave on pclk; clock inputs are muxed, never sampled.
// Notes: Zero-wait APB; read data is captured in the setup cycle.
//
// How it works
// - System clock comes from fast clock at 0, slow clock at 1; reset 0.
// - Clock out pin carries slow clock at 0, gear clock at 1; reset 0.
// - Warm-up field picks 2^8, 2^14 or 2^16 periods; 00 reserved; reset 10.
// - Standby field picks stop, idle-one or idle-two on halt; reset 11.
// - In stop or idle-one, pins go off unless pin hold is 1.
// - Unused clock select bits 7:4 and mode bits 7,1 read undefined.
// - Key 1Fh clears protection, any other key sets it; flag at bit 7.
// - Writing 1 to warm-up flag starts timer; it reads 1 until done.
`timescale 1ns/1ps
`include "scc_defines.svh"
`default_nettype none

module scc_top
  import scc_pkg::*;
#(
  parameter logic [16:0] WUP_MID_CYC = `SCC_WUP_MID_CYC,
  parameter logic [16:0] WUP_LONG_CYC = `SCC_WUP_LONG_CYC
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic fast_oscillator_clock,
  input wire logic slow_oscillator_clock,
  input wire logic gear_clock,
  input wire logic halt_active,
  output logic system_clock,
  output logic clock_out_pin,
  output logic pins_io_off,
  output logic warmup_busy,
  output var scc_ctrl_s ctrl
);

  scc_state_s st_r;
  scc_state_s st_nxt;
  logic [9:0] idx;
  logic aligned;
  logic setup_rd;
  logic acc_wr;
  logic mapped;
  logic guarded;
  logic wup_start;
  logic [16:0] wup_len;
  logic [7:0] wb;

  // Address decode; only word-aligned accesses reach a register.
  assign idx = paddr[11:2];
  assign aligned = (paddr[1:0] == 2'h0);
  assign wb = pwdata[7:0];
  assign setup_rd = psel && !penable && !pwrite;
  assign acc_wr = psel && penable && pwrite;

  always_comb
  begin
    mapped = 1'b0;
    guarded = 1'b0;
    if (aligned)
    begin
      unique case (idx)
        `SCC_IDX_CTRL0, `SCC_IDX_CLKSEL, `SCC_IDX_MODE, `SCC_IDX_NOISE:
        begin
          mapped = 1'b1;
          guarded = 1'b1;
        end
        `SCC_IDX_KEY, `SCC_IDX_DBL_A, `SCC_IDX_DBL_B:
          mapped = 1'b1;
        default:
          mapped = 1'b0;
      endcase
    end
  end

  // Every access completes in its first access cycle.
  assign pready = 1'b1;

  // Errors flag unmapped addresses and writes blocked by protection.
  assign pslverr = psel && penable &&
                   (!mapped || (pwrite && guarded && st_r.ctrl.protect));

  // The timer starts on an accepted write of 1 to the warm-up flag bit.
  assign wup_start = acc_wr && aligned && (idx == `SCC_IDX_CTRL0) &&
                     !st_r.ctrl.protect && wb[`SCC_CTRL0_WUF];

  // Reserved code 00 falls back to the shortest wait rather than none.
  always_comb
  begin
    unique case (st_r.ctrl.warmup_time_sel)
      2'b10: wup_len = WUP_MID_CYC;
      2'b11: wup_len = WUP_LONG_CYC;
      default: wup_len = `SCC_WUP_SHORT_CYC;
    endcase
  end

  scc_warmup u_warmup
  (
    .pclk(pclk),
    .presetn(presetn),
    .start(wup_start),
    .length(wup_len),
    .busy(warmup_busy)
  );

  // Next state: register writes in the access cycle, read data in setup.
  always_comb
  begin
    st_nxt = st_r;
    if (acc_wr && aligned)
    begin
      if (!st_r.ctrl.protect)
      begin
        unique case (idx)
          `SCC_IDX_CTRL0:
            st_nxt.ctrl.prescaler_source_sel = wb[1:0];
          `SCC_IDX_CLKSEL:
          begin
            st_nxt.ctrl.system_clock_source_sel =
              wb[`SCC_CLKSEL_SRC];
            st_nxt.ctrl.gear_sel = wb[2:0];
          end
          `SCC_IDX_MODE:
          begin
            st_nxt.ctrl.clock_out_sel = wb[`SCC_MODE_CLKOUT];
            st_nxt.ctrl.warmup_time_sel =
              wb[`SCC_MODE_WUP_LO +: 2];
            st_nxt.ctrl.standby_mode =
              scc_standby_e'(wb[`SCC_MODE_STB_LO +: 2]);
            st_nxt.ctrl.standby_pin_hold = wb[`SCC_MODE_HOLD];
          end
          `SCC_IDX_NOISE:
          begin
            st_nxt.spare = wb[`SCC_NOISE_SPARE_LO +: 3];
            st_nxt.ctrl.latch_strobe_out_enable =
              wb[`SCC_NOISE_ALE];
            st_nxt.ctrl.external_fast_clock_in = wb[`SCC_NOISE_EXT];
            st_nxt.ctrl.fast_osc_drive = wb[`SCC_NOISE_DRVH];
            st_nxt.ctrl.slow_osc_drive = wb[`SCC_NOISE_DRVL];
          end
          default:
          begin
          end
        endcase
      end
      // The key and the doubler registers stay writable under protection.
      unique case (idx)
        `SCC_IDX_KEY:
          st_nxt.ctrl.protect = (wb != `SCC_KEY_OPEN);
        `SCC_IDX_DBL_A:
          st_nxt.dbl_a_tm = wb[`SCC_DBL_A_TM];
        `SCC_IDX_DBL_B:
          st_nxt.dbl_b = wb;
        default:
        begin
        end
      endcase
    end
    // Unused bits read as zero, one legal choice for undefined values.
    if (setup_rd)
    begin
      st_nxt.rdata = 8'h00;
      if (aligned)
      begin
        unique case (idx)
          `SCC_IDX_CTRL0:
          begin
            st_nxt.rdata[`SCC_CTRL0_WUF] =
              warmup_busy || wup_start;
            st_nxt.rdata[1:0] = st_r.ctrl.prescaler_source_sel;
          end
          `SCC_IDX_CLKSEL:
          begin
            st_nxt.rdata[`SCC_CLKSEL_SRC] =
              st_r.ctrl.system_clock_source_sel;
            st_nxt.rdata[2:0] = st_r.ctrl.gear_sel;
          end
          `SCC_IDX_MODE:
          begin
            st_nxt.rdata[`SCC_MODE_CLKOUT] = st_r.ctrl.clock_out_sel;
            st_nxt.rdata[`SCC_MODE_WUP_LO +: 2] =
              st_r.ctrl.warmup_time_sel;
            st_nxt.rdata[`SCC_MODE_STB_LO +: 2] = st_r.ctrl.standby_mode;
            st_nxt.rdata[`SCC_MODE_HOLD] =
              st_r.ctrl.standby_pin_hold;
          end
          `SCC_IDX_NOISE:
          begin
            st_nxt.rdata[`SCC_NOISE_PROT] = st_r.ctrl.protect;
            st_nxt.rdata[`SCC_NOISE_SPARE_LO +: 3] = st_r.spare;
            st_nxt.rdata[`SCC_NOISE_ALE] =
              st_r.ctrl.latch_strobe_out_enable;
            st_nxt.rdata[`SCC_NOISE_EXT] = st_r.ctrl.external_fast_clock_in;
            st_nxt.rdata[`SCC_NOISE_DRVH] = st_r.ctrl.fast_osc_drive;
            st_nxt.rdata[`SCC_NOISE_DRVL] = st_r.ctrl.slow_osc_drive;
          end
          `SCC_IDX_DBL_A:
            st_nxt.rdata[`SCC_DBL_A_TM] = st_r.dbl_a_tm;
          `SCC_IDX_DBL_B:
            st_nxt.rdata = st_r.dbl_b;
          default:
            st_nxt.rdata = 8'h00;
        endcase
      end
    end
  end

  // State register; reset gives the documented defaults.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_r <= '0;
      st_r.ctrl.gear_sel <= `SCC_RST_GEAR;
      st_r.ctrl.warmup_time_sel <= `SCC_RST_WUP;
      st_r.ctrl.standby_mode <= SCC_STB_IDLE_TWO;
      st_r.ctrl.fast_osc_drive <= 1'b1;
      st_r.ctrl.slow_osc_drive <= 1'b1;
      st_r.spare <= `SCC_RST_SPARE;
      st_r.dbl_b <= `SCC_RST_DBL_B;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign prdata = {24'h000000, st_r.rdata};
  assign ctrl = st_r.ctrl;

  // Glitch-free switching is left to the clock cells that follow.
  assign system_clock = st_r.ctrl.system_clock_source_sel ?
                        slow_oscillator_clock :
                        fast_oscillator_clock;
  assign clock_out_pin = st_r.ctrl.clock_out_sel ?
                         gear_clock : slow_oscillator_clock;

  // Idle-two keeps pins live; stop and idle-one honour pin hold.
  assign pins_io_off = halt_active && !st_r.ctrl.standby_pin_hold &&
                       (st_r.ctrl.standby_mode == SCC_STB_STOP ||
                        st_r.ctrl.standby_mode == SCC_STB_IDLE_ONE);

  // Checks on the design's own outputs.
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_key_open_clears: assert property (
    acc_wr && idx == `SCC_IDX_KEY && aligned && wb == `SCC_KEY_OPEN
    |=> !ctrl.protect)
    else $error("Open key did not clear protection.");

  a_key_other_sets: assert property (
    acc_wr && idx == `SCC_IDX_KEY && aligned && wb != `SCC_KEY_OPEN
    |=> ctrl.protect)
    else $error("Other key did not set protection.");

  a_protected_hold: assert property (
    ctrl.protect && acc_wr && idx == `SCC_IDX_MODE
    |=> $stable(ctrl.standby_mode) && $stable(ctrl.warmup_time_sel))
    else $error("Protected register changed.");

  a_warmup_short_len: assert property (
    wup_start && ctrl.warmup_time_sel == 2'b01
    |=> warmup_busy [*8] ##248 warmup_busy ##1 !warmup_busy)
    else $error("Short warm-up length wrong.");

  a_warmup_read_flag: assert property (
    setup_rd && idx == `SCC_IDX_CTRL0 && aligned && warmup_busy
    |=> prdata[`SCC_CTRL0_WUF])
    else $error("Warm-up flag not read as busy.");

  a_sysclk_write: assert property (
    acc_wr && aligned && idx == `SCC_IDX_CLKSEL && !ctrl.protect
    |=> ctrl.system_clock_source_sel == $past(wb[`SCC_CLKSEL_SRC]))
    else $error("System clock select not written.");

  a_pins_off: assert property (
    halt_active && ctrl.standby_mode == SCC_STB_IDLE_ONE
    && !ctrl.standby_pin_hold |-> pins_io_off)
    else $error("Pins not switched off in idle-one.");

  a_idle_two_live: assert property (
    ctrl.standby_mode == SCC_STB_IDLE_TWO |-> !pins_io_off)
    else $error("Pins switched off in idle-two.");

  a_drive_write: assert property (
    acc_wr && aligned && idx == `SCC_IDX_NOISE && !ctrl.protect
    |=> ctrl.fast_osc_drive == $past(wb[`SCC_NOISE_DRVH])
        && ctrl.latch_strobe_out_enable == $past(wb[`SCC_NOISE_ALE]))
    else $error("Noise control write lost.");

  a_unused_zero: assert property (
    setup_rd && aligned && idx == `SCC_IDX_CLKSEL |=> prdata[7:4] == 4'h0)
    else $error("Unused clock select bits not zero.");

  c_warmup_run: cover property (wup_start ##1 warmup_busy);
  c_protect_on: cover property (!ctrl.protect ##1 ctrl.protect);
  c_err_resp: cover property (pslverr);
  c_standby_off: cover property (pins_io_off);

endmodule

`default_nettype wire

// file: verification/tb_system_clock_config_regs.sv
// Purpose: Self-checking bench for the clock configuration registers.
// Assumes: Zero-wait APB slave; shortened warm-up lengths of 20 and 40.
// Notes: Random data from a fixed seed, plus hand-picked corner cases.
`timescale 1ns/1ps
`default_nettype none

module tb_system_clock_config_regs
  import scc_pkg::*;
;
  localparam logic [16:0] MID_CYC = 17'h00014;
  localparam logic [16:0] LONG_CYC = 17'h00028;
  logic pclk, presetn, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, er;
  logic fast_osc, slow_osc, gear_clk, halt_active;
  logic system_clock, clock_out_pin, pins_io_off, warmup_busy;
  scc_ctrl_s ctrl;
  int err_count, tests_run, busy_cnt, n;
  logic [7:0] d, d1, d3, last_e1;
  logic [9:0] ri [0:5];
  logic [7:0] rv [0:5];

  scc_top #(.WUP_MID_CYC(MID_CYC), .WUP_LONG_CYC(LONG_CYC)) scc_top_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .fast_oscillator_clock(fast_osc),
    .slow_oscillator_clock(slow_osc), .gear_clock(gear_clk),
    .halt_active(halt_active), .system_clock(system_clock),
    .clock_out_pin(clock_out_pin), .pins_io_off(pins_io_off),
    .warmup_busy(warmup_busy), .ctrl(ctrl));

  // Free-running bench clock at 125 MHz.
  initial
  begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  // Clock inputs toggle at random so a wrong mux leg shows quickly.
  always @(posedge pclk)
  begin
    fast_osc <= 1'($urandom);
    slow_osc <= 1'($urandom);
    gear_clk <= 1'($urandom);
  end

  // Counts cycles the warm-up timer reports busy, sampled before each edge.
  always @(posedge pclk)
    if (warmup_busy === 1'b1)
      busy_cnt <= busy_cnt + 1;

  function automatic logic [11:0] ba(input logic [9:0] idx);
    return {idx, 2'b00};
  endfunction

  function automatic int wup_len(input logic [1:0] code);
    return (code == 2'b10) ? int'(MID_CYC) :
      (code == 2'b11) ? int'(LONG_CYC) : 256;
  endfunction

  // Pins go off only in stop or idle-one, during halt, without pin hold.
  function automatic logic exp_off(input logic [1:0] m, input logic h,
    input logic hlt);
    return hlt & ~h & ((m == 2'b01) | (m == 2'b10));
  endfunction

  task automatic test_done();
    $display("checks %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp,
    input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      $display("wrong value %s: expected %h, seen %h", nm, exp, got);
      err_count++;
    end
  endtask

  // One APB transfer; the request holds until pready is seen high.
  task automatic apb(input logic wr, input logic [11:0] a,
    input logic [7:0] wd);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, wd};
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 16);
    if (pready !== 1'b1)
    begin
      err_count++;
      test_done();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input string nm, input logic [11:0] a,
    input logic [7:0] exp);
    apb(1'b0, a, 8'h00);
    chk(nm, {24'h0, exp}, rd);
  endtask

  // Both clock muxes are compared over several random clock cycles.
  task automatic chk_mux(input logic sel, input logic cos);
    repeat (4)
    begin
      @(posedge pclk);
      #2;
      chk("system_clock", sel ? slow_osc : fast_osc, system_clock);
      chk("clock_out_pin", cos ? gear_clk : slow_osc, clock_out_pin);
    end
  endtask

  initial
  begin
    {psel, penable, pwrite, presetn, halt_active} = '0;
    {fast_osc, slow_osc, gear_clk} = '0;
    paddr = '0;
    pwdata = '0;
    busy_cnt = 0;
    err_count = 0;
    tests_run = 0;
    rd = $urandom(32'h41CE);
    ri = '{10'h0E0, 10'h0E1, 10'h0E2, 10'h0E3, 10'h0E4, 10'h0E8};
    rv = '{8'h00, 8'h04, 8'h2C, 8'h23, 8'h00, 8'h00};
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values of every register that software may touch, except the DBL_B doubler register.
    for (int i = 0; i < 6; i++)
      rdchk("reset_value", ba(ri[i]), rv[i]);
    chk_mux(1'b0, 1'b0);
    // Unmapped and misaligned places answer with an error and zero.
    apb(1'b1, 12'h3FC, 8'h5A);
    rdchk("unmapped", 12'h3FC, 8'h00);
    chk("unmapped_err", 32'h1, {31'h0, er});
    apb(1'b0, 12'h389, 8'h00);
    chk("misaligned_err", 32'h1, {31'h0, er});
    // Random settings, each read back and seen at the outputs.
    for (int i = 0; i < 12; i++)
    begin
      d = 8'($urandom);
      d1 = 8'($urandom);
      d3 = 8'($urandom);
      halt_active <= 1'($urandom);
      apb(1'b1, ba(10'h0E2), d);
      rdchk("mode", ba(10'h0E2), d & 8'h7D);
      chk("pins_io_off", exp_off(d[3:2], d[0], halt_active),
        pins_io_off);
      chk("standby", d[3:2], ctrl.standby_mode);
      chk("warmup_sel", d[5:4], ctrl.warmup_time_sel);
      apb(1'b1, ba(10'h0E1), d1);
      rdchk("clksel", ba(10'h0E1), d1 & 8'h0F);
      chk_mux(d1[3], d[6]);
      apb(1'b1, ba(10'h0E3), d3);
      rdchk("noise", ba(10'h0E3), d3 & 8'h7F);
      chk("ale", d3[3], ctrl.latch_strobe_out_enable);
      chk("drives", d3[1:0],
        {ctrl.fast_osc_drive, ctrl.slow_osc_drive});
    end
    // Hand-picked corners: idle-one without hold, stop with hold.
    halt_active <= 1'b1;
    apb(1'b1, ba(10'h0E2), 8'h08);
    rdchk("mode_idle_one", ba(10'h0E2), 8'h08);
    chk("idle_one_off", 32'h1, {31'h0, pins_io_off});
    apb(1'b1, ba(10'h0E2), 8'h05);
    rdchk("mode_stop_hold", ba(10'h0E2), 8'h05);
    chk("stop_hold", 32'h0, {31'h0, pins_io_off});
    // Prescaler field without a timer start.
    apb(1'b1, ba(10'h0E0), 8'h02);
    rdchk("prescaler", ba(10'h0E0), 8'h02);
    halt_active <= 1'b0;
    // Drives back to normal before any oscillator restart.
    apb(1'b1, ba(10'h0E3), 8'h23);
    // Every warm-up code, including the reserved one, timed in cycles.
    for (int c = 0; c < 4; c++)
    begin
      apb(1'b1, ba(10'h0E2), {2'b00, 2'(c), 4'hC});
      busy_cnt = 0;
      apb(1'b1, ba(10'h0E0), 8'h04);
      rdchk("warmup_flag_busy", ba(10'h0E0), 8'h04);
      n = 0;
      while (warmup_busy === 1'b1 && n < 400)
      begin
        @(posedge pclk);
        n++;
      end
      if (n >= 400)
      begin
        err_count++;
        test_done();
      end
      @(posedge pclk);
      chk("warmup_len", wup_len(2'(c)), busy_cnt);
      rdchk("warmup_flag_done", ba(10'h0E0), 8'h00);
    end
    // Any key but the open value locks; writes are then refused.
    last_e1 = d1 & 8'h0F;
    apb(1'b1, ba(10'h0E4), 8'h00);
    rdchk("protect_on", ba(10'h0E3), 8'hA3);
    rdchk("key_read", ba(10'h0E4), 8'h00);
    apb(1'b1, ba(10'h0E1), 8'h0A);
    chk("locked_err", 32'h1, {31'h0, er});
    rdchk("locked_keep", ba(10'h0E1), last_e1);
    apb(1'b1, ba(10'h0E2), 8'h00);
    chk("locked_mode_err", 32'h1, {31'h0, er});
    rdchk("locked_mode", ba(10'h0E2), 8'h3C);
    apb(1'b1, ba(10'h0E4), 8'h1E);
    rdchk("protect_near_key", ba(10'h0E3), 8'hA3);
    apb(1'b1, ba(10'h0E4), 8'h1F);
    rdchk("protect_off", ba(10'h0E3), 8'h23);
    apb(1'b1, ba(10'h0E1), 8'h0A);
    chk("open_err", 32'h0, {31'h0, er});
    rdchk("open_write", ba(10'h0E1), 8'h0A);
    test_done();
  end
endmodule

`default_nettype wire
